// ### sfm_params.svh
// Constants for the serial field memory: offsets, reset values, counts.
// Assumes inclusion by the package, the design module, the checker and the bench.
`ifndef SFM_PARAMS_SVH
`define SFM_PARAMS_SVH

`define SFM_DEPTH      1114112
`define SFM_LAST_ADDR  21'h10_FFFF
`define SFM_AW         21
`define SFM_DW         24
`define SFM_LAT        4
`define SFM_LOAD_CLKS  5'h15
`define SFM_OLD_GUARD  31

`define SFM_CTRL_OFF   12'h000
`define SFM_WSTART_OFF 12'h004
`define SFM_RSTART_OFF 12'h008
`define SFM_WPTR_OFF   12'h00C
`define SFM_RPTR_OFF   12'h010
`define SFM_STAT_OFF   12'h014

`define SFM_CTRL_RST   2'h3
`define SFM_START_RST  21'h00_0000
`define SFM_CTRL_WEN   0
`define SFM_CTRL_REN   1

`endif

// ### sfm_pkg.sv
// Types shared by the serial field memory design.
// Assumes the constants header is on the include path.
`include "sfm_params.svh"

package sfm_pkg;

    typedef enum logic [1:0] {SFM_UNINIT, SFM_LOAD, SFM_RUN} sfm_state_t;

    typedef logic [`SFM_AW-1:0] sfm_addr_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } sfm_apb_in_t;

    typedef struct packed {
        logic                write_clock;
        logic                write_pointer_reset;
        logic                write_advance_enable;
        logic                write_mask_enable;
        logic [`SFM_DW-1:0]  data;
    } sfm_wr_in_t;

    typedef struct packed {
        logic read_clock;
        logic read_pointer_reset;
        logic read_advance_enable;
        logic output_drive_enable;
    } sfm_rd_in_t;

    typedef struct packed {
        sfm_state_t state;
        logic [4:0] cnt;
        sfm_addr_t  ptr;
    } sfm_side_t;

    typedef struct packed {
        logic               adv;
        logic               gate;
        logic [`SFM_DW-1:0] data;
    } sfm_stage_t;

    typedef struct packed {
        logic               vld;
        sfm_addr_t          addr;
        logic [`SFM_DW-1:0] data;
    } sfm_commit_t;

endpackage

// ### sfm_field_memory.sv
// Serial field memory core: write port, read port, storage, APB registers.
// Assumes port clocks and controls are synchronous to pclk, below half its rate.
//
// Summary of operation
// - Write clock, pointer reset, advance and mask enables govern writing.
// - Advance and mask select increment-and-store, increment-only, or halt.
// - Write advance acts four write clocks after sampling.
// - Write mask acts on data acceptance four write clocks after sampling.
// - Pointer reset starts a 21-clock load; advance acts from the next clock.
// - Read clock, pointer reset, advance and drive enables govern reading.
// - Read advance steers the pointer; drive enable steers output drive.
// - Read advance acts on the read pointer four read clocks later.
// - Drive enable switches output drive four read clocks later.
// - Read pointer reset starts a 21-clock load; advance acts from the next clock.
// - Distance 0 to 30 returns previously stored data.
// - Other distances may return either; writes still store correctly.
// - Both sides load their start address by one shared procedure.
`timescale 1ns/1ps
`default_nettype none
`include "sfm_params.svh"

module sfm_field_memory import sfm_pkg::*; (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire sfm_apb_in_t apb_in,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Write port
    input  wire sfm_wr_in_t  wr_in,
    // Read port
    input  wire sfm_rd_in_t  rd_in,
    output logic [`SFM_DW-1:0] rd_data,
    output logic             rd_data_oe
);

    function automatic sfm_addr_t next_ptr(input sfm_addr_t p);
        if (p == `SFM_LAST_ADDR) begin
            return '0;
        end
        return p + 21'h00_0001;
    endfunction

    function automatic sfm_side_t side_next(input sfm_side_t s, input logic rst,
                                            input logic adv, input sfm_addr_t start);
        sfm_side_t n;
        n = s;
        if (rst) begin
            n.state = SFM_LOAD;
            n.cnt   = `SFM_LOAD_CLKS;
            n.ptr   = start;
        end else begin
            case (s.state)
                SFM_LOAD: begin
                    // Pointer frozen until the load count runs out
                    n.cnt = s.cnt - 5'h01;
                    if (s.cnt == 5'h01) begin
                        n.state = SFM_RUN;
                    end
                end
                default: begin
                    // Dummy clocks before the first reset also move the pointer
                    if (adv) begin
                        n.ptr = next_ptr(s.ptr);
                    end
                end
            endcase
        end
        return n;
    endfunction

    // Storage
    logic [`SFM_DW-1:0] mem [0:`SFM_DEPTH-1];

    // Register state
    logic [1:0]   ctrl_q, ctrl_d;
    sfm_addr_t    wstart_q, wstart_d;
    sfm_addr_t    rstart_q, rstart_d;
    logic [31:0]  prdata_q, prdata_d;
    logic         pready_q, pready_d;
    logic         pslverr_q, pslverr_d;

    // Port state
    logic         wclk_q, rclk_q;
    logic         wedge, redge;
    sfm_side_t    ws_q, ws_d, rs_q, rs_d;
    sfm_stage_t   wp_q [0:`SFM_LAT-1];
    sfm_stage_t   wp_d [0:`SFM_LAT-1];
    sfm_stage_t   rp_q [0:`SFM_LAT-1];
    sfm_stage_t   rp_d [0:`SFM_LAT-1];
    sfm_commit_t  cq_q [0:`SFM_OLD_GUARD-1];
    sfm_commit_t  cq_d [0:`SFM_OLD_GUARD-1];
    logic [`SFM_DW-1:0] rdat_q [0:`SFM_LAT-2];
    logic [`SFM_DW-1:0] rdat_d [0:`SFM_LAT-2];
    logic [`SFM_DW-1:0] rd_data_q, rd_data_d;
    logic         rd_oe_q, rd_oe_d;
    sfm_commit_t  cq_tail;

    assign wedge = ctrl_q[`SFM_CTRL_WEN] & wr_in.write_clock & ~wclk_q;
    assign redge = ctrl_q[`SFM_CTRL_REN] & rd_in.read_clock & ~rclk_q;
    assign cq_tail = cq_q[`SFM_OLD_GUARD-1];

    always_comb begin
        ws_d = ws_q;
        for (int i = 0; i < `SFM_LAT; i++) begin
            wp_d[i] = wp_q[i];
        end
        for (int i = 0; i < `SFM_OLD_GUARD; i++) begin
            cq_d[i] = cq_q[i];
        end
        if (wedge) begin
            wp_d[0] = '{adv:  wr_in.write_advance_enable,
                        gate: wr_in.write_mask_enable,
                        data: wr_in.data};
            for (int i = 1; i < `SFM_LAT; i++) begin
                wp_d[i] = wp_q[i-1];
            end
            // Commit held back past the old-data guard
            for (int i = 1; i < `SFM_OLD_GUARD; i++) begin
                cq_d[i] = cq_q[i-1];
            end
            // Store only when advancing and unmasked
            // Mask taken from the delayed stage
            cq_d[0] = '{vld:  wp_q[`SFM_LAT-1].adv & wp_q[`SFM_LAT-1].gate &
                              (ws_q.state == SFM_RUN) & ~wr_in.write_pointer_reset,
                        addr: ws_q.ptr,
                        data: wp_q[`SFM_LAT-1].data};
            ws_d = side_next(ws_q, wr_in.write_pointer_reset,
                             wp_q[`SFM_LAT-1].adv, wstart_q);
        end
    end

    always_comb begin
        rs_d      = rs_q;
        rd_data_d = rd_data_q;
        rd_oe_d   = rd_oe_q;
        for (int i = 0; i < `SFM_LAT; i++) begin
            rp_d[i] = rp_q[i];
        end
        for (int i = 0; i < `SFM_LAT-1; i++) begin
            rdat_d[i] = rdat_q[i];
        end
        if (redge) begin
            rp_d[0] = '{adv:  rd_in.read_advance_enable,
                        gate: rd_in.output_drive_enable,
                        data: '0};
            for (int i = 1; i < `SFM_LAT; i++) begin
                rp_d[i] = rp_q[i-1];
            end
            // Read latency of four edges from pointer to pins
            rdat_d[0] = mem[rs_q.ptr];
            for (int i = 1; i < `SFM_LAT-1; i++) begin
                rdat_d[i] = rdat_q[i-1];
            end
            rd_data_d = rdat_q[`SFM_LAT-2];
            rd_oe_d   = rp_q[`SFM_LAT-1].gate;
            rs_d = side_next(rs_q, rd_in.read_pointer_reset,
                             rp_q[`SFM_LAT-1].adv, rstart_q);
        end
    end

    // Late commit lands in storage only on a later enabled write edge
    always_ff @(posedge pclk) begin
        if (wedge && cq_tail.vld) begin
            mem[cq_tail.addr] <= cq_tail.data;
        end
    end

    // APB access; one wait state keeps prdata registered
    always_comb begin
        logic acc;
        logic fire;
        acc       = apb_in.psel & apb_in.penable & ~pready_q;
        fire      = apb_in.psel & apb_in.penable & pready_q & apb_in.pwrite;
        ctrl_d    = ctrl_q;
        wstart_d  = wstart_q;
        rstart_d  = rstart_q;
        pready_d  = acc;
        pslverr_d = 1'b0;
        prdata_d  = '0;
        if (apb_in.paddr == `SFM_CTRL_OFF) begin
            prdata_d = {30'h0000_0000, ctrl_q};
            if (fire) begin
                ctrl_d = apb_in.pwdata[1:0];
            end
        end else if (apb_in.paddr == `SFM_WSTART_OFF) begin
            prdata_d = {11'h000, wstart_q};
            if (fire) begin
                wstart_d = apb_in.pwdata[`SFM_AW-1:0];
            end
        end else if (apb_in.paddr == `SFM_RSTART_OFF) begin
            prdata_d = {11'h000, rstart_q};
            if (fire) begin
                rstart_d = apb_in.pwdata[`SFM_AW-1:0];
            end
        end else if (apb_in.paddr == `SFM_WPTR_OFF) begin
            prdata_d = {11'h000, ws_q.ptr};
        end else if (apb_in.paddr == `SFM_RPTR_OFF) begin
            prdata_d = {11'h000, rs_q.ptr};
        end else if (apb_in.paddr == `SFM_STAT_OFF) begin
            prdata_d = {28'h000_0000,
                        rs_q.state == SFM_RUN, ws_q.state == SFM_RUN,
                        rs_q.state == SFM_LOAD, ws_q.state == SFM_LOAD};
        end else begin
            pslverr_d = acc;
        end
        if (!acc || apb_in.pwrite) begin
            prdata_d = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q    <= `SFM_CTRL_RST;
            wstart_q  <= `SFM_START_RST;
            rstart_q  <= `SFM_START_RST;
            prdata_q  <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            wclk_q    <= 1'b0;
            rclk_q    <= 1'b0;
            ws_q      <= '{state: SFM_UNINIT, cnt: 5'h00, ptr: '0};
            rs_q      <= '{state: SFM_UNINIT, cnt: 5'h00, ptr: '0};
            rd_data_q <= '0;
            rd_oe_q   <= 1'b0;
            for (int i = 0; i < `SFM_LAT; i++) begin
                wp_q[i] <= '0;
                rp_q[i] <= '0;
            end
            for (int i = 0; i < `SFM_LAT-1; i++) begin
                rdat_q[i] <= '0;
            end
            for (int i = 0; i < `SFM_OLD_GUARD; i++) begin
                cq_q[i] <= '0;
            end
        end else begin
            ctrl_q    <= ctrl_d;
            wstart_q  <= wstart_d;
            rstart_q  <= rstart_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            wclk_q    <= wr_in.write_clock;
            rclk_q    <= rd_in.read_clock;
            ws_q      <= ws_d;
            rs_q      <= rs_d;
            rd_data_q <= rd_data_d;
            rd_oe_q   <= rd_oe_d;
            for (int i = 0; i < `SFM_LAT; i++) begin
                wp_q[i] <= wp_d[i];
                rp_q[i] <= rp_d[i];
            end
            for (int i = 0; i < `SFM_LAT-1; i++) begin
                rdat_q[i] <= rdat_d[i];
            end
            for (int i = 0; i < `SFM_OLD_GUARD; i++) begin
                cq_q[i] <= cq_d[i];
            end
        end
    end

    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign rd_data    = rd_data_q;
    assign rd_data_oe = rd_oe_q;

endmodule

`default_nettype wire

// ### sfm_field_memory_monitor.sv
// Checker on the field memory ports: APB answer timing, read output timing.
// Assumes port clocks are sampled on pclk, as the core samples them.
`timescale 1ns/1ps
`default_nettype none
`include "sfm_params.svh"
module sfm_field_memory_monitor import sfm_pkg::*; (
    // Clock and reset
    input wire logic               pclk,
    input wire logic               presetn,
    // APB
    input wire sfm_apb_in_t        apb_in,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    // Read port
    input wire sfm_rd_in_t         rd_in,
    input wire logic [`SFM_DW-1:0] rd_data,
    input wire logic               rd_data_oe
);
    logic       rclk_q;
    logic [3:0] drv_q;
    logic [3:0] drv_d;
    logic       redge;
    // Edge found from the read clock alone, without the ctrl_q read enable gating the core uses
    assign redge = rd_in.read_clock && !rclk_q;
    always_comb begin
        drv_d = redge ? {drv_q[2:0], rd_in.output_drive_enable} : drv_q;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rclk_q <= 1'b0;
            drv_q  <= 4'h0;
        end else begin
            rclk_q <= rd_in.read_clock;
            drv_q  <= drv_d;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_access;
        apb_in.psel && apb_in.penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_ready_follows: assert property (s_access |=> s_answer)
        else $error("no single pready after access");
    a_ready_cause: assert property (pready |-> $past(apb_in.psel && apb_in.penable))
        else $error("pready without access");
    a_err_pairs: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata nonzero while idle");
    a_write_zero: assert property (pready && apb_in.pwrite |-> prdata == 32'h0000_0000)
        else $error("prdata nonzero on write");
    a_drive_latency: assert property (redge |=> rd_data_oe == $past(drv_q[3]))
        else $error("drive enable latency wrong");
    a_drive_holds: assert property (!redge |=> $stable(rd_data_oe))
        else $error("drive changed between edges");
    a_data_holds: assert property (!redge |=> $stable(rd_data))
        else $error("read data changed between edges");
endmodule
bind sfm_field_memory sfm_field_memory_monitor i_sfm_field_memory_monitor (
    .pclk, .presetn, .apb_in, .prdata, .pready, .pslverr, .rd_in, .rd_data, .rd_data_oe);
`default_nettype wire

// ### sfm_port_drv.sv
// Controller model for one port: port clock, pointer reset and enables.
// Assumes pclk at 50 MHz; a port clock period is four pclk cycles.
`timescale 1ns/1ps
`default_nettype none
module sfm_port_drv (
    // Clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // Bench requests
    input  wire logic   pause,
    input  wire logic   adv_req,
    input  wire logic   en_req,
    // Port pins
    output logic        port_clk,
    output logic        ptr_rst,
    output logic        adv,
    output logic        en,
    // Advances the pointer should show, edge count
    output logic [20:0] exp_adv,
    output logic [9:0]  n_q
);
    logic [1:0] ph_q;
    logic [3:0] sh_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {ph_q, sh_q, port_clk, ptr_rst, adv, en} <= '0;
            exp_adv <= 21'h00_0000;
            n_q     <= 10'h000;
        end else if (!(pause && ph_q == 2'h0)) begin
            // Clock halts low only, between edges
            ph_q     <= ph_q + 2'h1;
            port_clk <= ph_q == 2'h1 || ph_q == 2'h2;
            if (ph_q == 2'h1) begin
                n_q     <= n_q + {9'h000, n_q != 10'h3FF};
                sh_q    <= ptr_rst ? 4'h0 : {sh_q[2:0], adv};
                exp_adv <= ptr_rst ? 21'h00_0000 : exp_adv + {20'h0_0000, sh_q[3]};
            end
            if (ph_q == 2'h3) begin
                ptr_rst <= n_q == 10'h096;
                adv     <= n_q >= 10'h0C0 && (n_q < 10'h1B0 || adv_req);
                en      <= n_q >= 10'h0C0 && (n_q < 10'h1B0 || en_req);
            end
        end
    end
endmodule
`default_nettype wire

// ### serial_field_memory_fifo_control_tb.sv
// Bench for the field memory: registers over APB, pointer motion per port.
// Assumes the port model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "sfm_params.svh"
module serial_field_memory_fifo_control_tb import sfm_pkg::*; ;
    logic               pclk, presetn, wp, rp, wa, wm, ra, rd, pready, pslverr, oe, eq;
    logic [31:0]        prdata, rq, seed, r;
    logic [`SFM_DW-1:0] wdata, rdat;
    logic [20:0]        wexp, rexp, wst, rst_a;
    logic [9:0]         wn;
    sfm_apb_in_t        apb_in;
    wire sfm_wr_in_t    wr_in;
    wire sfm_rd_in_t    rd_in;
    int                 err_total, compares;
    assign wr_in.data = wdata;
    sfm_field_memory i_sfm_field_memory (.pclk, .presetn, .apb_in, .prdata, .pready,
        .pslverr, .wr_in, .rd_in, .rd_data(rdat), .rd_data_oe(oe));
    sfm_port_drv wdrv (.pclk, .presetn, .pause(wp), .adv_req(wa), .en_req(wm),
        .port_clk(wr_in.write_clock), .ptr_rst(wr_in.write_pointer_reset),
        .adv(wr_in.write_advance_enable), .en(wr_in.write_mask_enable), .exp_adv(wexp), .n_q(wn));
    sfm_port_drv rdrv (.pclk, .presetn, .pause(rp), .adv_req(ra), .en_req(rd),
        .port_clk(rd_in.read_clock), .ptr_rst(rd_in.read_pointer_reset),
        .adv(rd_in.read_advance_enable), .en(rd_in.output_drive_enable), .exp_adv(rexp), .n_q());
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Pointer wraps to zero past the last word
    function automatic logic [31:0] exp_ptr(input logic [20:0] st, input logic [20:0] c);
        return 32'((22'(st) + 22'(c)) % 22'h11_0000);
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Holds the request until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge pclk);
        apb_in <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        apb_in.penable <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1);
        rq = prdata;
        eq = pslverr;
        apb_in <= '0;
        // One wait state, answer in the cycle after the access phase
        chk(32'(t), 32'h0000_0002);
    endtask
    task automatic wait_n(input logic [9:0] k);
        while (wn < k) @(posedge pclk);
    endtask
    task automatic give_verdict();
        $display("compares %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        give_verdict();
    end
    initial begin
        {presetn, wp, rp, wa, wm, ra, rd, wdata, apb_in} = '0;
        {err_total, compares} = '0;
        seed = 32'h0000_CB87;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0000_0000);
            chk(rq, (i == 0) ? 32'h0000_0003 : 32'h0000_0000);
        end
        apb(1'b1, 12'h018, 32'hFFFF_FFFF);
        chk({rq[30:0], eq}, 32'h0000_0001);
        apb(1'b1, `SFM_WPTR_OFF, 32'h0000_1234);
        apb(1'b0, `SFM_WPTR_OFF, 32'h0000_0000);
        chk(rq, 32'h0000_0000);
        wst = 21'h10_FFF0;
        rst_a = 21'(rnd() % 32'h0011_0000);
        apb(1'b1, `SFM_WSTART_OFF, {11'h000, wst});
        apb(1'b1, `SFM_RSTART_OFF, {11'h000, rst_a});
        apb(1'b0, `SFM_WSTART_OFF, 32'h0000_0000);
        chk(rq, {11'h000, wst}); // shared start format
        apb(1'b0, `SFM_RSTART_OFF, 32'h0000_0000);
        chk(rq, {11'h000, rst_a}); // shared start format
        $display("test registers done");
        wait_n(10'h0A0);
        apb(1'b0, `SFM_STAT_OFF, 32'h0000_0000);
        chk(rq, 32'h0000_0003); // load after reset
        wait_n(10'h1B0);
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            {wa, wm, ra, rd} <= r[3:0];
            wdata <= r[31:8];
            repeat (r[7:4] * 4 + 8) @(posedge pclk);
            {wp, rp} <= 2'h3;
            repeat (12) @(posedge pclk);
            apb(1'b0, `SFM_WPTR_OFF, 32'h0000_0000);
            chk(rq, exp_ptr(wst, wexp)); // write pointer
            apb(1'b0, `SFM_RPTR_OFF, 32'h0000_0000);
            chk(rq, exp_ptr(rst_a, rexp)); // read pointer
            apb(1'b0, `SFM_STAT_OFF, 32'h0000_0000);
            chk(rq, 32'h0000_000C); // run state
            {wp, rp} <= 2'h0;
        end
        $display("test pointers done");
        // Write port frozen by its enable bit; pointer must not move
        repeat (8) @(posedge pclk);
        {wp, rp} <= 2'h3;
        repeat (12) @(posedge pclk);
        r = exp_ptr(wst, wexp);
        apb(1'b1, `SFM_CTRL_OFF, 32'h0000_0002);
        wa <= 1'b1;
        wp <= 1'b0;
        repeat (40) @(posedge pclk);
        wp <= 1'b1;
        repeat (12) @(posedge pclk);
        apb(1'b0, `SFM_WPTR_OFF, 32'h0000_0000);
        chk(rq, r); // halted write port
        $display("test freeze done");
        // Mid-run reset; storage keeps the zero words of the first pass
        {wp, rp} <= 2'h0;
        wdata <= 24'h5A_A5C3;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SFM_CTRL_OFF, 32'h0000_0000);
        chk(rq, 32'h0000_0003);
        // Both pointers restart at zero, so reads run at distance zero
        wait_n(10'h0D0);
        for (int k = 0; k < 6; k++) begin
            repeat (16) @(posedge pclk);
            chk({7'h00, oe, rdat}, 32'h0100_0000); // old words only
        end
        $display("test old data done");
        give_verdict();
    end
endmodule
`default_nettype wire
